// ===== src/tmwm_pkg.sv
// package of constants and types for the 8-bit waveform-mode timer
package tmwm_pkg;
  // waveform mode encodings
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CLEAR_MATCH = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_CMPA = 3'h5;
  localparam logic [2:0] WM_FAST_CMPA = 3'h7;
  // compare output mode encodings
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // count extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPB = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_FORCE = 8'h14;
  // control field positions
  localparam int CTRL_WM_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_DIRA_BIT = 8;
  localparam int CTRL_DIRB_BIT = 9;
  // flag positions
  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMPA_BIT = 1;
  localparam int FLG_CMPB_BIT = 2;
  // reset values
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  // slope direction of the counter
  typedef enum logic {TMWM_UP = 1'b0, TMWM_DOWN = 1'b1} tmwm_dir_type;
endpackage : tmwm_pkg

// ===== src/tmwm_channel.sv
// one compare channel: buffer, match detect, output waveform state
`timescale 1ns/1ns
module tmwm_channel
  import tmwm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // timer state from the counter
  input wire logic tick,
  input wire logic [2:0] waveMode,
  input wire logic [1:0] compareOutputMode,
  input wire logic [7:0] counterValue,
  input wire logic [7:0] topValue,
  input wire logic countDown,
  input wire logic atTop,
  input wire logic wrapToBottom,
  input wire logic matchBlock,
  input wire logic isTopChannel,
  // software access
  input wire logic cmpWrite,
  input wire logic [7:0] cmpWdata,
  input wire logic forceStrobe,
  // results
  output logic [7:0] compareValue,
  output logic [7:0] compareBuf,
  output logic matchSeen,
  output logic compareOutput
);
  ////////////////////////////////////////////////////////////////////////
  // mode decode
  function automatic logic isPwm(input logic [2:0] m);
    isPwm = (m == WM_FAST_FF) || (m == WM_FAST_CMPA) || (m == WM_PC_FF) || (m == WM_PC_CMPA);
  endfunction : isPwm
  function automatic logic isFast(input logic [2:0] m);
    isFast = (m == WM_FAST_FF) || (m == WM_FAST_CMPA);
  endfunction : isFast

  logic [7:0] compareValue_q; // active compare value
  logic [7:0] compareBuf_q; // software-written buffer
  logic outState_q; // internal output state, kept across mode changes
  logic match; // comparator hit this timer tick
  logic pwm;
  logic updatePoint; // where the buffer reaches the active register
  logic toggleOk; // toggle in pwm modes only for channel A in the top-defining modes

  assign pwm = isPwm(waveMode);
  // fast pwm updates at bottom wrap, phase correct at top
  assign updatePoint = isFast(waveMode) ? wrapToBottom : atTop;
  assign match = tick && !matchBlock && (counterValue == compareValue_q);
  assign toggleOk = !pwm || (isTopChannel && waveMode[2]);

  ////////////////////////////////////////////////////////////////////////
  // compare buffering: direct in non-pwm modes, deferred in pwm
  always_ff @(posedge mclk) begin
    if (srst) begin
      compareBuf_q <= CMP_RESET;
      compareValue_q <= CMP_RESET;
    end else begin
      if (cmpWrite) begin
        compareBuf_q <= cmpWdata;
      end
      if (cmpWrite && !pwm) begin
        compareValue_q <= cmpWdata;
      end else if (pwm && tick && updatePoint) begin
        compareValue_q <= compareBuf_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output waveform state
  always_ff @(posedge mclk) begin
    if (srst) begin
      outState_q <= 1'b0;
    end else if (!pwm) begin
      // off means no action; new mode used at the next match
      if ((match || forceStrobe) && compareOutputMode != COM_OFF) begin
        case (compareOutputMode)
          COM_TOGGLE: outState_q <= !outState_q;
          COM_CLEAR: outState_q <= 1'b0;
          COM_SET: outState_q <= 1'b1;
          default: outState_q <= outState_q;
        endcase
      end
    end else if (compareOutputMode == COM_TOGGLE) begin
      if (match && toggleOk) begin
        outState_q <= !outState_q;
      end
    end else if (compareOutputMode[1]) begin
      if (isFast(waveMode)) begin
        // match at top is ignored; the wrap action decides the level
        if (tick && wrapToBottom) begin
          outState_q <= (compareOutputMode == COM_CLEAR);
        end else if (match && compareValue_q != topValue) begin
          outState_q <= (compareOutputMode == COM_SET);
        end
      end else if (match) begin
        // clear on the way up for non-inverting, set on the way down
        outState_q <= (compareOutputMode == COM_SET) ^ countDown;
      end
    end
  end

  assign compareValue = compareValue_q;
  assign compareBuf = compareBuf_q;
  assign matchSeen = match;
  assign compareOutput = outState_q;
endmodule : tmwm_channel

// ===== src/tmwm_timer.sv
// top of the 8-bit waveform-mode timer with apb registers
// How it works
// - output mode zero takes no action
// - new output mode acts at next match
// - count sequence ignores output mode bits
// - mode zero counts up and wraps
// - normal mode overflow flag at zero
// - counter writable at any time
// - clear-on-match mode clears at compare A
// - low compare A write wraps through max
// - clear-on-match toggle output on each match
// - clear-on-match overflow flag at max wrap
// - fast pwm top is max or A
// - fast pwm clears after reaching top
// - fast pwm clear/set at match and wrap
// - fast pwm overflow flag at top
// - fast pwm period is 256 ticks with top at max
// - fast pwm extreme compare values handled
// - fast pwm toggle keeps compare buffering
// - phase correct top is max or A
// - phase correct sets/clears by slope direction
// - output state settable before pin enabled
// - phase correct holds top one tick
// - phase correct overflow flag at bottom
// - counter write blocks next tick match
// - match sets compare flag next tick
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
module tmwm_timer
  import tmwm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // timer clock enable from the prescaler (same clock domain)
  input wire logic timerTick,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // compare outputs with pin enables
  output logic compareAOutput,
  output logic compareAOe,
  output logic compareBOutput,
  output logic compareBOe,
  // flags
  output logic overflowFlag,
  output logic compareAFlag,
  output logic compareBFlag
);
  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic apbAccess; // access phase, answered at once
  logic wrEn;
  logic hitCtrl, hitCount, hitCmpA, hitCmpB, hitFlags, hitForce, hitAny;
  assign apbAccess = psel && penable;
  assign wrEn = apbAccess && pwrite;
  assign hitCtrl = (paddr == OFS_CTRL);
  assign hitCount = (paddr == OFS_COUNT);
  assign hitCmpA = (paddr == OFS_CMPA);
  assign hitCmpB = (paddr == OFS_CMPB);
  assign hitFlags = (paddr == OFS_FLAGS);
  assign hitForce = (paddr == OFS_FORCE);
  assign hitAny = hitCtrl | hitCount | hitCmpA | hitCmpB | hitFlags | hitForce;

  ////////////////////////////////////////////////////////////////////////
  // control register: modes and pin directions
  logic [9:0] ctrl_q;
  logic [2:0] waveMode;
  logic [1:0] comA;
  logic [1:0] comB;
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrEn && hitCtrl) begin
      ctrl_q <= pwdata[9:0]; // output mode change acts at the next match
    end
  end
  assign waveMode = ctrl_q[CTRL_WM_LSB +: 3];
  assign comA = ctrl_q[CTRL_COMA_LSB +: 2];
  assign comB = ctrl_q[CTRL_COMB_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // counter unit; the sequence reads only the waveform mode
  function automatic logic isFastMode(input logic [2:0] m);
    isFastMode = (m == WM_FAST_FF) || (m == WM_FAST_CMPA);
  endfunction : isFastMode
  function automatic logic isPcMode(input logic [2:0] m);
    isPcMode = (m == WM_PC_FF) || (m == WM_PC_CMPA);
  endfunction : isPcMode

  logic [7:0] counterValue_q;
  logic [7:0] counterValue_d;
  tmwm_dir_type dir_q;
  tmwm_dir_type dir_d;
  logic [7:0] topValue; // highest value of the pwm sequences
  logic [7:0] cmpAValue;
  logic [7:0] cmpBValue;
  logic [7:0] cmpABuf;
  logic [7:0] cmpBBuf;
  logic atTop;
  logic atBottom;
  logic wrapToBottom; // fast pwm passing top to bottom
  logic countWrite;
  logic blockNext_q; // match blocking after a counter write
  logic ovfEvent;

  assign countWrite = wrEn && hitCount;
  // mode 3 and 1 use max, 7 and 5 use compare A
  assign topValue = waveMode[2] ? cmpAValue : CNT_MAX;
  assign atTop = (counterValue_q == topValue);
  assign atBottom = (counterValue_q == CNT_BOTTOM);
  assign wrapToBottom = isFastMode(waveMode) && atTop;

  // next count value and direction
  always_comb begin
    counterValue_d = counterValue_q;
    dir_d = dir_q;
    case (waveMode)
      WM_CLEAR_MATCH: begin
        // clear on match with A; a low A means wrapping through max first
        if (counterValue_q == cmpAValue) begin
          counterValue_d = CNT_BOTTOM;
        end else begin
          counterValue_d = counterValue_q + 8'h01;
        end
      end
      WM_FAST_FF, WM_FAST_CMPA: begin
        // count up to top then bottom on the next tick
        if (atTop) begin
          counterValue_d = CNT_BOTTOM;
        end else begin
          counterValue_d = counterValue_q + 8'h01;
        end
      end
      WM_PC_FF, WM_PC_CMPA: begin
        // top and bottom each last one tick, then direction turns
        if (dir_q == TMWM_UP && atTop) begin
          dir_d = TMWM_DOWN;
          counterValue_d = counterValue_q - 8'h01;
        end else if (dir_q == TMWM_DOWN && atBottom) begin
          dir_d = TMWM_UP;
          counterValue_d = counterValue_q + 8'h01;
        end else if (dir_q == TMWM_UP) begin
          counterValue_d = counterValue_q + 8'h01;
        end else begin
          counterValue_d = counterValue_q - 8'h01;
        end
      end
      default: begin
        // normal mode and reserved: plain up count with wrap
        counterValue_d = counterValue_q + 8'h01;
      end
    endcase
    if (!isPcMode(waveMode)) begin
      dir_d = TMWM_UP;
    end
  end

  // counter register; a software write has priority at any time
  always_ff @(posedge mclk) begin
    if (srst) begin
      counterValue_q <= COUNT_RESET;
      dir_q <= TMWM_UP;
    end else if (countWrite) begin
      counterValue_q <= pwdata[7:0];
    end else if (timerTick) begin
      counterValue_q <= counterValue_d;
      dir_q <= dir_d;
    end
  end

  // a counter write blocks matches until the next timer tick has passed
  always_ff @(posedge mclk) begin
    if (srst) begin
      blockNext_q <= 1'b0;
    end else if (countWrite) begin
      blockNext_q <= 1'b1;
    end else if (timerTick) begin
      blockNext_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow event per mode, taken on the tick where the state arises
  always_comb begin
    case (waveMode)
      WM_FAST_FF, WM_FAST_CMPA: ovfEvent = atTop;
      WM_PC_FF, WM_PC_CMPA: ovfEvent = atBottom && dir_q == TMWM_DOWN;
      default: ovfEvent = (counterValue_q == CNT_MAX) && counterValue_d == CNT_BOTTOM;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // compare channels
  logic matchA, matchB; // comparator hits this tick
  logic outA, outB; // internal waveform states
  logic forceA, forceB; // force strobes per channel
  logic pwmActive;
  assign pwmActive = isFastMode(waveMode) || isPcMode(waveMode);
  // force applies only in non-pwm modes
  assign forceA = wrEn && hitForce && pwdata[0] && !pwmActive;
  assign forceB = wrEn && hitForce && pwdata[1] && !pwmActive;

  tmwm_channel chanA (
    .mclk(mclk),
    .srst(srst),
    .tick(timerTick),
    .waveMode(waveMode),
    .compareOutputMode(comA),
    .counterValue(counterValue_q),
    .topValue(topValue),
    .countDown(dir_q == TMWM_DOWN),
    .atTop(atTop),
    .wrapToBottom(wrapToBottom),
    .matchBlock(blockNext_q),
    .isTopChannel(1'b1),
    .cmpWrite(wrEn && hitCmpA),
    .cmpWdata(pwdata[7:0]),
    .forceStrobe(forceA),
    .compareValue(cmpAValue),
    .compareBuf(cmpABuf),
    .matchSeen(matchA),
    .compareOutput(outA)
  );
  tmwm_channel chanB (
    .mclk(mclk),
    .srst(srst),
    .tick(timerTick),
    .waveMode(waveMode),
    .compareOutputMode(comB),
    .counterValue(counterValue_q),
    .topValue(topValue),
    .countDown(dir_q == TMWM_DOWN),
    .atTop(atTop),
    .wrapToBottom(wrapToBottom),
    .matchBlock(blockNext_q),
    .isTopChannel(1'b0),
    .cmpWrite(wrEn && hitCmpB),
    .cmpWdata(pwdata[7:0]),
    .forceStrobe(forceB),
    .compareValue(cmpBValue),
    .compareBuf(cmpBBuf),
    .matchSeen(matchB),
    .compareOutput(outB)
  );

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over a write-one clear in the same cycle
  logic ovf_q;
  logic flagA_q;
  logic flagB_q;
  logic pendA_q; // match seen, flag raised at the following tick
  logic pendB_q;
  logic clrOvf, clrA, clrB;
  assign clrOvf = wrEn && hitFlags && pwdata[FLG_OVF_BIT];
  assign clrA = wrEn && hitFlags && pwdata[FLG_CMPA_BIT];
  assign clrB = wrEn && hitFlags && pwdata[FLG_CMPB_BIT];

  always_ff @(posedge mclk) begin
    if (srst) begin
      ovf_q <= 1'b0;
    end else if (timerTick && ovfEvent) begin
      ovf_q <= 1'b1;
    end else if (clrOvf) begin
      ovf_q <= 1'b0;
    end
  end

  // compare flags lag the match by one timer tick
  always_ff @(posedge mclk) begin
    if (srst) begin
      pendA_q <= 1'b0;
      pendB_q <= 1'b0;
      flagA_q <= 1'b0;
      flagB_q <= 1'b0;
    end else begin
      if (matchA) begin
        pendA_q <= 1'b1;
      end else if (timerTick) begin
        pendA_q <= 1'b0;
      end
      if (matchB) begin
        pendB_q <= 1'b1;
      end else if (timerTick) begin
        pendB_q <= 1'b0;
      end
      if (timerTick && pendA_q) begin
        flagA_q <= 1'b1;
      end else if (clrA) begin
        flagA_q <= 1'b0;
      end
      if (timerTick && pendB_q) begin
        flagB_q <= 1'b1;
      end else if (clrB) begin
        flagB_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers: state is kept even while the pin is disabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      compareAOutput <= 1'b0;
      compareAOe <= 1'b0;
      compareBOutput <= 1'b0;
      compareBOe <= 1'b0;
    end else begin
      compareAOutput <= outA;
      compareBOutput <= outB;
      // drive only with output mode connected and direction set
      compareAOe <= ctrl_q[CTRL_DIRA_BIT] && comA != COM_OFF;
      compareBOe <= ctrl_q[CTRL_DIRB_BIT] && comB != COM_OFF;
    end
  end
  assign overflowFlag = ovf_q;
  assign compareAFlag = flagA_q;
  assign compareBFlag = flagB_q;
  ////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, error on unmapped address
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hitAny;
      if (psel && !penable && !pwrite) begin
        prdata <= 32'h0000_0000;
        if (hitCtrl) prdata[9:0] <= ctrl_q;
        if (hitCount) prdata[7:0] <= counterValue_q;
        if (hitCmpA) prdata[7:0] <= cmpABuf;
        if (hitCmpB) prdata[7:0] <= cmpBBuf;
        if (hitFlags) prdata[2:0] <= {flagB_q, flagA_q, ovf_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_normal_wrap: assert property (@(posedge mclk) disable iff (srst)
    waveMode == WM_NORMAL && timerTick && !countWrite && counterValue_q == CNT_MAX
    |=> counterValue_q == CNT_BOTTOM) else $error("normal mode did not wrap to zero");
  chk_ctc_clear: assert property (@(posedge mclk) disable iff (srst)
    waveMode == WM_CLEAR_MATCH && timerTick && !countWrite && counterValue_q == cmpAValue
    |=> counterValue_q == CNT_BOTTOM) else $error("clear-on-match did not clear");
  chk_fast_top: assert property (@(posedge mclk) disable iff (srst)
    isFastMode(waveMode) && timerTick && !countWrite && atTop
    |=> counterValue_q == CNT_BOTTOM) else $error("fast pwm did not return to bottom");
  chk_pc_turn: assert property (@(posedge mclk) disable iff (srst)
    isPcMode(waveMode) && timerTick && !countWrite && atTop && dir_q == TMWM_UP
    && counterValue_q != CNT_BOTTOM |=> dir_q == TMWM_DOWN)
    else $error("phase correct did not reverse at top");
  chk_ovf_sets: assert property (@(posedge mclk) disable iff (srst)
    timerTick && ovfEvent |=> ovf_q) else $error("overflow flag not set");
  chk_write_block: assert property (@(posedge mclk) disable iff (srst)
    countWrite |=> !matchA && !matchB) else $error("match not blocked after counter write");
  chk_flag_lag: assert property (@(posedge mclk) disable iff (srst)
    matchA ##1 !timerTick ##1 timerTick |=> flagA_q) else $error("compare flag not set");
  chk_apb_ready: assert property (@(posedge mclk) disable iff (srst)
    psel && !penable |=> pready) else $error("apb access not answered");
endmodule : tmwm_timer

// ===== test/test_tmwm_timer.sv
// self-checking bench for the waveform-mode timer, driven over apb
`timescale 1ns/1ns
module test_tmwm_timer;
  import tmwm_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and timer tick
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic timerTick = 1'b0;
  // apb request side, all driven by the bench
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  // design answers
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic compareAOutput;
  logic compareAOe;
  logic compareBOutput;
  logic compareBOe;
  logic overflowFlag;
  logic compareAFlag;
  logic compareBFlag;
  // what the last transfer returned
  logic [31:0] rdata;
  logic rerr;
  // tallies
  int miscompares = 0;
  int checked = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  tmwm_timer dut (
    .mclk(mclk), .srst(srst), .timerTick(timerTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compareAOutput(compareAOutput), .compareAOe(compareAOe),
    .compareBOutput(compareBOutput), .compareBOe(compareBOe),
    .overflowFlag(overflowFlag), .compareAFlag(compareAFlag),
    .compareBFlag(compareBFlag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one comparison; four-state equality so an unknown never matches
  task cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : cmp

  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // wait for the answer; a slave that never answers is left to the watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdata, exp);
  endtask : rd

  // n timer ticks spaced apart, then let registered outputs settle
  task tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      timerTick <= 1'b1;
      @(posedge mclk);
      timerTick <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : tk

  // control word from its fields
  function logic [31:0] ctl(input logic [2:0] w, input logic [1:0] a, input logic [1:0] b,
                            input logic da, input logic db);
    ctl = 32'(w) | (32'(a) << CTRL_COMA_LSB) | (32'(b) << CTRL_COMB_LSB);
    ctl = ctl | (32'(da) << CTRL_DIRA_BIT) | (32'(db) << CTRL_DIRB_BIT);
  endfunction : ctl

  task end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 75 us, so 400 us means a hang
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd(OFS_COUNT, 32'h0000_0000);
    rd(OFS_CTRL, 32'h0000_0000);
    // output mode off ignores the strobe, set mode obeys it
    wr(OFS_CTRL, ctl(WM_NORMAL, COM_OFF, COM_OFF, 1'b0, 1'b0));
    wr(OFS_FORCE, 32'h0000_0001);
    tk(0);
    cmp(32'(compareAOutput), 32'h0);
    wr(OFS_CTRL, ctl(WM_NORMAL, COM_SET, COM_SET, 1'b0, 1'b0));
    wr(OFS_FORCE, 32'h0000_0003);
    tk(0);
    cmp(32'(compareAOutput), 32'h1);
    cmp(32'(compareBOutput), 32'h1);
    cmp(32'(compareAOe), 32'h0);
    wr(OFS_CTRL, ctl(WM_NORMAL, COM_SET, COM_SET, 1'b1, 1'b1));
    tk(0);
    cmp(32'(compareAOe), 32'h1);
    cmp(32'(compareBOe), 32'h1);
    $display("force test done");
    // normal mode wrap and overflow flag
    wr(OFS_COUNT, 32'h0000_00FE);
    tk(1);
    rd(OFS_COUNT, 32'h0000_00FF);
    cmp(32'(overflowFlag), 32'h0);
    tk(1);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(overflowFlag), 32'h1);
    wr(OFS_FLAGS, 32'h0000_0001);
    tk(0);
    cmp(32'(overflowFlag), 32'h0);
    // a counter write hides the match in the next tick only
    wr(OFS_CMPA, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0003);
    tk(3);
    rd(OFS_COUNT, 32'h0000_0006);
    cmp(32'(compareAFlag), 32'h0);
    wr(OFS_COUNT, 32'h0000_0001);
    tk(4);
    cmp(32'(compareAFlag), 32'h1);
    wr(OFS_FLAGS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h0000_0000);
    $display("normal test done");
    // clear-on-match with toggling output; output starts high
    wr(OFS_CTRL, ctl(WM_CLEAR_MATCH, COM_TOGGLE, COM_OFF, 1'b1, 1'b0));
    wr(OFS_CMPA, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0000);
    tk(4);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(compareAOutput), 32'h0);
    tk(4);
    cmp(32'(compareAOutput), 32'h1);
    cmp(32'(overflowFlag), 32'h0);
    // top written below the count: runs on through max first
    tk(2);
    wr(OFS_CMPA, 32'h0000_0001);
    tk(253);
    rd(OFS_COUNT, 32'h0000_00FF);
    tk(1);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(overflowFlag), 32'h1);
    tk(2);
    rd(OFS_COUNT, 32'h0000_0000);
    $display("clear-on-match test done");
    // fast pwm, top at max, clear on match and set at wrap
    wr(OFS_FLAGS, 32'h0000_0007);
    wr(OFS_CMPA, 32'h0000_0080);
    wr(OFS_COUNT, 32'h0000_007E);
    wr(OFS_CTRL, ctl(WM_FAST_FF, COM_CLEAR, COM_OFF, 1'b1, 1'b0));
    tk(3);
    cmp(32'(compareAOutput), 32'h0);
    tk(126);
    rd(OFS_COUNT, 32'h0000_00FF);
    tk(1);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(overflowFlag), 32'h1);
    cmp(32'(compareAOutput), 32'h1);
    // new compare value waits in the buffer until the next wrap
    wr(OFS_CMPA, 32'h0000_0040);
    rd(OFS_CMPA, 32'h0000_0040);
    tk(65);
    cmp(32'(compareAOutput), 32'h1);
    $display("fast pwm test done");
    // phase correct, top at max, inverting output
    wr(OFS_CTRL, ctl(WM_PC_FF, COM_SET, COM_OFF, 1'b1, 1'b0));
    wr(OFS_COUNT, 32'h0000_00FD);
    wr(OFS_FLAGS, 32'h0000_0007);
    tk(2);
    rd(OFS_COUNT, 32'h0000_00FF);
    tk(1);
    rd(OFS_COUNT, 32'h0000_00FE);
    tk(254);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(compareAOutput), 32'h0);
    tk(1);
    cmp(32'(overflowFlag), 32'h1);
    tk(80);
    cmp(32'(compareAOutput), 32'h1);
    $display("phase correct test done");
    // fast pwm with top at A: A toggles per period, B spikes low at bottom
    wr(OFS_CTRL, ctl(WM_NORMAL, COM_OFF, COM_OFF, 1'b0, 1'b0));
    wr(OFS_CMPA, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_FLAGS, 32'h0000_0007);
    wr(OFS_CTRL, ctl(WM_FAST_CMPA, COM_TOGGLE, COM_SET, 1'b1, 1'b1));
    tk(4);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(compareAOutput), 32'h0);
    cmp(32'(compareBOutput), 32'h0);
    cmp(32'(overflowFlag), 32'h1);
    tk(1);
    cmp(32'(compareBOutput), 32'h1);
    cmp(32'(compareAFlag), 32'h1);
    tk(1);
    cmp(32'(compareBFlag), 32'h1);
    tk(2);
    rd(OFS_COUNT, 32'h0000_0000);
    cmp(32'(compareAOutput), 32'h1);
    cmp(32'(compareBOutput), 32'h0);
    $display("fast pwm top at A test done");
    // unmapped address is refused and reads zero
    wr(8'h20, 32'hFFFF_FFFF);
    cmp(32'(rerr), 32'h1);
    apb(1'b0, 8'h20, 32'h0000_0000);
    cmp(rdata, 32'h0000_0000);
    cmp(32'(rerr), 32'h1);
    $display("unmapped test done");
    end_of_test();
  end
endmodule : test_tmwm_timer
